/* File: txbs_top.v */
// Transmit phase FIFO followed by the optional byte serializer
`include "txbs_defines.vh"

// What this block does
// - FIFO absorbs phase between fabric and parallel clock
// - FIFO holds exactly four words
// - Normal latency two to three parallel cycles
// - Fixed-latency mode removes two parallel cycles: one fill word, one stage
// - Fabric word is 8, 10, 16 or 20
// - Coded symbol out is 8 or 10 bits
// - Serializer splits word, doubles output rate
// - Low half goes out before high half
// - PCIe mode takes words from PIPE port
module txbs_top (
	input wire i_clock,
	input wire i_rstn,
	input wire i_fab_clk,
	input wire [19:0] i_fab_data,
	input wire [19:0] i_pipe_data,
	input wire i_pipe_mode,
	input wire i_wide,
	input wire i_ten_bit,
	input wire i_ser_en,
	input wire i_fixed_lat,
	output wire o_wr_ready,
	output reg o_overflow,
	output reg [9:0] o_sym_data,
	output reg o_sym_valid
);

	localparam WW = `TXBS_WORD_W;
	localparam SW = `TXBS_SYM_W;
	localparam CW = `TXBS_CNT_W;
	// Counts worked out as integers, then cut to the slot counter width
	localparam integer WORD_LAST_I = `TXBS_WORD_CYC - 1;
	localparam integer HALF_AT_I = `TXBS_HALF_CYC;
	localparam [CW-1:0] WORD_LAST = WORD_LAST_I[CW-1:0];
	localparam [CW-1:0] HALF_AT = HALF_AT_I[CW-1:0];

	// Read side states, one-hot
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_FILL = 3'b010;
	localparam [2:0] ST_RUN = 3'b100;

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers: link clock and word pass two flops first
	reg fclk_s1_q; // First stage, read only by second stage
	reg fclk_s2_q; // Safe copy of the link clock
	reg fclk_s3_q; // Previous safe copy, for edge finding
	reg [WW-1:0] dat_s1_q; // First stage of the fabric word
	reg [WW-1:0] dat_s2_q; // Safe fabric word
	reg [WW-1:0] pip_s1_q; // First stage of the PIPE word
	reg [WW-1:0] pip_s2_q; // Safe PIPE word
	reg pmode_s1_q; // First stage of PIPE select
	reg pmode_s2_q; // Safe PIPE select

	always @(posedge i_clock) begin
		if (!i_rstn) begin
			fclk_s1_q <= 1'b0;
			fclk_s2_q <= 1'b0;
			fclk_s3_q <= 1'b0;
			dat_s1_q <= {WW{1'b0}};
			dat_s2_q <= {WW{1'b0}};
			pip_s1_q <= {WW{1'b0}};
			pip_s2_q <= {WW{1'b0}};
			pmode_s1_q <= 1'b0;
			pmode_s2_q <= 1'b0;
		end else begin
			fclk_s1_q <= i_fab_clk;
			fclk_s2_q <= fclk_s1_q;
			fclk_s3_q <= fclk_s2_q;
			// No logic ahead of the first stage: both sources synced
			dat_s1_q <= i_fab_data;
			dat_s2_q <= dat_s1_q;
			pip_s1_q <= i_pipe_data;
			pip_s2_q <= pip_s1_q;
			pmode_s1_q <= i_pipe_mode;
			pmode_s2_q <= pmode_s1_q;
		end
	end

	// Word is latched by the writer on its rising edge, so the word
	// changes together with it; both travel the same two-flop delay.
	wire fclk_rise = fclk_s2_q && !fclk_s3_q;

	// PIPE port feeds the FIFO in PCIe mode, picked after the syncs
	wire [WW-1:0] src_word = pmode_s2_q ? pip_s2_q : dat_s2_q;

	////////////////////////////////////////////////////////////////////
	// Width trim per configured fabric width
	reg [WW-1:0] wr_word;

	always @* begin
		wr_word = src_word;
		case ({i_wide, i_ten_bit})
			2'b00: wr_word = {12'h000, src_word[7:0]};
			2'b01: wr_word = {10'h000, src_word[9:0]};
			2'b10: wr_word = {4'h0, src_word[15:0]};
			default: wr_word = src_word;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Four-word phase FIFO between write edge and read slot
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [WW-1:0] fifo_out_data;
	wire [`TXBS_FIFO_AW:0] fifo_count;
	reg pop_q; // Pop strobe from the read slot

	txbs_fifo #(
		.WIDTH(WW),
		.DEPTH(`TXBS_FIFO_DEPTH),
		.AW(`TXBS_FIFO_AW)
	) u_fifo (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_in_valid(fclk_rise),
		.o_in_ready(fifo_in_ready),
		.i_in_data(wr_word),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(pop_q),
		.o_out_data(fifo_out_data),
		.o_count(fifo_count)
	);

	// Writer has no way to pause; ready is reported, loss is flagged
	assign o_wr_ready = fifo_in_ready;

	// Sticky overflow until reset: a word arrived with no room
	always @(posedge i_clock) begin
		if (!i_rstn) begin
			o_overflow <= 1'b0;
		end else if (fclk_rise && !fifo_in_ready) begin
			o_overflow <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Parallel clock, made from the own clock at the word rate
	reg [CW-1:0] slot_q; // Position inside one parallel cycle
	wire word_tick = (slot_q == WORD_LAST);
	// Mid slot, so both halves stand the same number of cycles
	wire half_tick = (slot_q == HALF_AT);

	always @(posedge i_clock) begin
		if (!i_rstn) begin
			slot_q <= {CW{1'b0}};
		end else if (word_tick) begin
			slot_q <= {CW{1'b0}};
		end else begin
			slot_q <= slot_q + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read side control: wait for fill, then pop one word per tick
	reg [2:0] st_q; // Read state
	reg [WW-1:0] stg_q; // Extra stage used only in elastic mode
	reg stg_v_q; // Extra stage holds a word
	reg [WW-1:0] out_word_q; // Word now being sent
	reg out_v_q; // Sent word is real
	reg tick_q; // Slot boundary, in step with pop_q
	// Registered mode needs one word, elastic mode keeps two waiting
	wire [`TXBS_FIFO_AW:0] fill_need = i_fixed_lat ? 3'h1 : 3'h2;

	// Pop on the parallel tick when a word is there
	always @(posedge i_clock) begin
		if (!i_rstn) begin
			pop_q <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			pop_q <= word_tick && fifo_out_valid && (st_q == ST_RUN);
			tick_q <= word_tick && (st_q == ST_RUN);
		end
	end

	// Start state machine
	always @(posedge i_clock) begin
		if (!i_rstn) begin
			st_q <= ST_IDLE;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (fifo_out_valid) begin
						st_q <= ST_FILL;
					end
				end
				ST_FILL: begin
					// Start once the chosen depth is reached
					if (fifo_count >= fill_need) begin
						st_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					st_q <= ST_RUN;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Latency pipe: pop lands in the output word at once in fixed mode
	// and one tick later, through the extra stage, in elastic mode
	always @(posedge i_clock) begin
		if (!i_rstn) begin
			stg_q <= {WW{1'b0}};
			stg_v_q <= 1'b0;
			out_word_q <= {WW{1'b0}};
			out_v_q <= 1'b0;
		end else if (pop_q) begin
			stg_q <= fifo_out_data;
			stg_v_q <= 1'b1;
			if (i_fixed_lat) begin
				out_word_q <= fifo_out_data;
				out_v_q <= 1'b1;
			end else begin
				out_word_q <= stg_q;
				out_v_q <= stg_v_q;
			end
		end else if (tick_q) begin
			// Underrun slot: fixed mode sends nothing, elastic mode sends the staged word. Judged on the pop
			// edge itself, so a normal pop is never taken for one.
			stg_v_q <= 1'b0;
			out_v_q <= i_fixed_lat ? 1'b0 : stg_v_q;
			out_word_q <= stg_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Byte serializer: low half first, high half at mid slot
	reg half_q; // High half is on the output
	reg [SW-1:0] low_half;
	reg [SW-1:0] high_half;

	// Split point follows the symbol width
	always @* begin
		if (i_ten_bit) begin
			low_half = out_word_q[9:0];
			high_half = out_word_q[19:10];
		end else begin
			low_half = {2'b00, out_word_q[7:0]};
			high_half = {2'b00, out_word_q[15:8]};
		end
	end

	// Output symbol register; the word slot starts one cycle after pop
	always @(posedge i_clock) begin
		if (!i_rstn) begin
			half_q <= 1'b0;
			o_sym_data <= 10'h000;
			o_sym_valid <= 1'b0;
		end else if (i_ser_en) begin
			// Low half restarts with the new word, not a cycle early
			if (tick_q) begin
				half_q <= 1'b0;
			end else if (half_tick) begin
				half_q <= 1'b1;
			end
			o_sym_data <= half_q ? high_half : low_half;
			o_sym_valid <= out_v_q;
		end else begin
			// Whole word is one symbol, trimmed to its width
			half_q <= 1'b0;
			o_sym_data <= i_ten_bit ? low_half : {2'b00, low_half[7:0]};
			o_sym_valid <= out_v_q;
		end
	end

endmodule // txbs_top

/* File: txbs_defines.vh */
// Constants for the transmit phase FIFO and byte serializer
`ifndef TXBS_DEFINES_VH
`define TXBS_DEFINES_VH

// Widths of the fabric word and of one coded symbol
`define TXBS_WORD_W 20
`define TXBS_SYM_W 10
`define TXBS_BYTE_W 8

// Phase FIFO geometry
`define TXBS_FIFO_DEPTH 4
`define TXBS_FIFO_AW 2

// Timing: own clock period and fabric word period, in ns
`define TXBS_CLK_NS 100
`define TXBS_WORD_NS 800
// Own clock cycles per parallel word, and per half word
`define TXBS_WORD_CYC (`TXBS_WORD_NS / `TXBS_CLK_NS)
`define TXBS_HALF_CYC (`TXBS_WORD_CYC / 2)
`define TXBS_CNT_W 3

// Parallel cycles a word waits in the normal, elastic mode
`define TXBS_NORM_STAGES 2

`endif

/* File: txbs_fifo.v */
// Small synchronous FIFO with valid and ready on both sides
module txbs_fifo #(
	parameter WIDTH = 20,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire i_clock,
	input wire i_rstn,
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [WIDTH-1:0] o_out_data,
	output wire [AW:0] o_count
);

	reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // Word storage
	reg [AW-1:0] wr_q; // Write pointer
	reg [AW-1:0] rd_q; // Read pointer
	reg [AW:0] cnt_q; // Occupancy

	wire push = i_in_valid && o_in_ready;
	wire pop = o_out_valid && i_out_ready;

	// Honest flags straight from occupancy
	assign o_in_ready = (cnt_q != DEPTH[AW:0]);
	assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
	assign o_out_data = mem_q[rd_q];
	assign o_count = cnt_q;

	////////////////////////////////////////////////////////////////////
	// Storage write, no reset needed for data
	always @(posedge i_clock) begin
		if (push) begin
			mem_q[wr_q] <= i_in_data;
		end
	end

	// Pointers and count
	always @(posedge i_clock) begin
		if (!i_rstn) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
			end else if (pop && !push) begin
				cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
			end
		end
	end

endmodule // txbs_fifo

/* File: txbs_top_properties.sv */
// Port checks for the transmit phase FIFO and byte serializer
module txbs_top_properties (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_fab_clk,
	input wire logic i_ten_bit,
	input wire logic i_ser_en,
	input wire logic i_fixed_lat,
	input wire logic o_wr_ready,
	input wire logic o_overflow,
	input wire logic [9:0] o_sym_data,
	input wire logic o_sym_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	// Single domain: one clock, one reset
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	////////////////////////////////////////////////////////////////
	a_sym_stands:
	assert property (o_sym_valid && !i_ser_en && $changed(o_sym_data)
		|=> $stable(o_sym_data)[*7]) else $error("symbol too short");
	a_half_stands:
	assert property (o_sym_valid && i_ser_en && $changed(o_sym_data)
		|=> $stable(o_sym_data)[*3]) else $error("half too short");
	a_byte_pad:
	assert property (o_sym_valid && !i_ten_bit |-> o_sym_data[9:8] == 2'h0)
		else $error("pad bits set");
	a_valid_holds:
	assert property (o_sym_valid |=> o_sym_valid) else $error("underrun");
	a_fill_bound:
	assert property ($rose(i_fab_clk) && !o_sym_valid |-> ##[1:80] o_sym_valid)
		else $error("output never started");
	a_no_drop:
	assert property (!o_overflow) else $error("word dropped");
	a_never_full:
	assert property (o_wr_ready) else $error("fifo full");
	a_ovf_sticky:
	assert property (o_overflow |=> o_overflow) else $error("flag lost");
	// Main modes reached
	c_fixed: cover property ($rose(o_sym_valid) && i_fixed_lat);
	c_elastic: cover property ($rose(o_sym_valid) && !i_fixed_lat);
	c_ser: cover property ($rose(o_sym_valid) && i_ser_en);
endmodule // txbs_top_properties

/* File: txbs_fab_model.sv */
// Fabric writer: one word per 800 ns, locked to the own clock
module txbs_fab_model (
	input wire logic i_rstn,
	input wire logic i_pipe_mode,
	output logic o_fab_clk,
	output logic [19:0] o_fab_data,
	output logic [19:0] o_pipe_data,
	output logic [19:0] o_word
);
	timeunit 1ns;
	timeprecision 1ns;
	// Clock stands low in reset; unused source carries the inverse
	initial begin
		o_fab_clk = 1'b0;
		o_word = 20'h00000;
		o_fab_data = 20'h00000;
		o_pipe_data = 20'h00000;
		forever begin
			@(posedge i_rstn);
			#37; // Phase offset off the own clock edges
			while (i_rstn) begin
				o_word = 20'($urandom);
				o_fab_data = i_pipe_mode ? ~o_word : o_word;
				o_pipe_data = i_pipe_mode ? o_word : ~o_word;
				o_fab_clk = 1'b1;
				#400;
				o_fab_clk = 1'b0;
				#400;
			end
		end
	end
endmodule // txbs_fab_model

/* File: txbs_top_tb_top.sv */
// Bench: eight modes, symbols compared with a queue model
module txbs_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rstn, wide, ten, ser, fix, pipe, fclk;
	logic [19:0] fdat, pdat, word;
	logic rdy, ovf, vld;
	logic [9:0] sym;
	int n_fail, checks;
	logic [19:0] q[$]; // Words the writer sent
	txbs_top uut (.i_clock(clk), .i_rstn(rstn), .i_fab_clk(fclk),
		.i_fab_data(fdat), .i_pipe_data(pdat), .i_pipe_mode(pipe),
		.i_wide(wide), .i_ten_bit(ten), .i_ser_en(ser), .i_fixed_lat(fix),
		.o_wr_ready(rdy), .o_overflow(ovf), .o_sym_data(sym),
		.o_sym_valid(vld));
	txbs_fab_model fab (.i_rstn(rstn), .i_pipe_mode(pipe), .o_fab_clk(fclk),
		.o_fab_data(fdat), .o_pipe_data(pdat), .o_word(word));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Data is settled by the fabric clock's fall
	always @(negedge fclk) if (rstn) q.push_back(word);
	////////////////////////////////////////////////////////////////
	task bad(input string m);
		n_fail++;
		$display("unexpected %0t %s", $time, m);
	endtask
	task conclude;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Bounded wait on a level, in own clock cycles
	// on_vld picks the watched level: symbol valid or fabric clock
	task automatic wait_for(input bit on_vld, input logic v, input int lim);
		int n;
		n = 0;
		while ((on_vld ? vld : fclk) !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
		if ((on_vld ? vld : fclk) !== v) begin
			bad("wait ran out");
			conclude();
		end
	endtask
	// One mode: reset, start, then compare mid-symbol
	task automatic run_cfg(input logic [2:0] c);
		int k;
		logic [19:0] w;
		logic [9:0] e;
		wait_for(1'b0, 1'b1, 20);
		wait_for(1'b0, 1'b0, 20);
		rstn = 1'b0;
		{wide, ten, fix, pipe} = {c[1], c[0], c[2], c[0] ^ c[2]};
		ser = c[1]; // Wide words always go through the serializer
		repeat (5) @(negedge clk);
		q.delete();
		rstn = 1'b1;
		wait_for(1'b1, 1'b1, 40);
		repeat (ser ? 2 : 4) @(negedge clk);
		for (k = 0; k < 12; k++) begin
			if (!ser || !k[0]) begin
				if (q.size() == 0) bad("model empty");
				w = (q.size() > 0) ? q.pop_front() : 20'h00000;
			end
			e = ten ? w[9:0] : {2'h0, w[7:0]};
			if (ser && k[0]) e = ten ? w[19:10] : {2'h0, w[15:8]};
			checks++;
			if (sym !== e) bad("symbol mismatch");
			if (vld !== 1'b1) bad("valid dropped");
			if (ovf !== 1'b0 || rdy !== 1'b1) bad("fifo flags");
			repeat (ser ? 4 : 8) @(negedge clk);
		end
	endtask
	initial begin
		{rstn, wide, ten, ser, fix, pipe} = 6'h00;
		n_fail = 0;
		checks = 0;
		void'($urandom(36));
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		for (int c = 0; c < 8; c++) run_cfg(3'(c));
		conclude();
	end
endmodule // txbs_top_tb_top
bind txbs_top txbs_top_properties chk (.i_clock(i_clock), .i_rstn(i_rstn),
	.i_fab_clk(i_fab_clk), .i_ten_bit(i_ten_bit), .i_ser_en(i_ser_en),
	.i_fixed_lat(i_fixed_lat), .o_wr_ready(o_wr_ready),
	.o_overflow(o_overflow), .o_sym_data(o_sym_data),
	.o_sym_valid(o_sym_valid));
